// file: hw/mode_reg_three_pkg.sv
// Constants for the third mode register decoder and its scratch store.
// Assumes one 250 MHz command clock shared with the memory controller.
package mode_reg_three_pkg;

  // ****************************************************************
  // Pin mapping of a mode register set
  // ****************************************************************
  localparam int          MR_WIDTH        = 22;
  localparam logic [2:0]  SEL_MR2         = 3'h2;
  localparam logic [2:0]  SEL_MR3         = 3'h3;
  localparam logic [2:0]  SEL_FORBIDDEN   = 3'h7;
  localparam int          POS_CRC_EN_MR2  = 12;
  localparam int          POS_RSV_21      = 21;
  localparam int          POS_RSV_17      = 17;
  localparam int          POS_RSV_13      = 13;
  localparam int          POS_FMT_LO      = 11;
  localparam int          POS_DLY_LO      = 9;
  localparam int          POS_REF_LO      = 6;
  localparam int          POS_TEMP_EN     = 5;
  localparam int          POS_PER_DEV     = 4;
  localparam int          POS_GEAR        = 3;
  localparam int          POS_ACCESS      = 2;
  localparam int          POS_PAGE_LO     = 0;

  // ****************************************************************
  // Field codes
  // ****************************************************************
  localparam logic [1:0]  FMT_RESERVED    = 2'h3;
  localparam logic [1:0]  DLY_CODE_4CK    = 2'h0;
  localparam logic [1:0]  DLY_CODE_5CK    = 2'h1;
  localparam logic [1:0]  DLY_CODE_6CK    = 2'h2;
  localparam logic [2:0]  DLY_CLK_4       = 3'h4;
  localparam logic [2:0]  DLY_CLK_5       = 3'h5;
  localparam logic [2:0]  DLY_CLK_6       = 3'h6;
  localparam logic [2:0]  REF_RSV_A       = 3'h3;
  localparam logic [2:0]  REF_RSV_B       = 3'h4;
  localparam logic [2:0]  REF_RSV_C       = 3'h7;
  localparam logic [1:0]  PAGE_PATTERN    = 2'h0;
  localparam logic [1:0]  PAGE_ERROR      = 2'h1;
  localparam logic [1:0]  PAGE_MODE_READ  = 2'h2;
  localparam logic [3:0]  BURST_UI_PLAIN  = 4'h8;
  localparam logic [3:0]  BURST_UI_CRC    = 4'hA;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  PATTERN_RESET   = 8'h00;
  localparam logic [2:0]  DLY_CLK_RESET   = 3'h0;

  // ****************************************************************
  // Temperature status refresh period
  // ****************************************************************
  localparam longint      CLK_PERIOD_PS   = 4000;
  localparam longint      TEMP_REFRESH_MS = 32;
  localparam int          TEMP_REFRESH_CYCLES =
    int'((TEMP_REFRESH_MS * 64'd1000000000) / CLK_PERIOD_PS);
  localparam int          TIMER_WIDTH     = 24;

  typedef enum logic [1:0] {
    MODE_NORMAL  = 2'b01,
    MODE_PATTERN = 2'b10
  } access_mode_type;

endpackage : mode_reg_three_pkg

// file: hw/status_refresh_timer.sv
// Period timer, cleared and held at zero while run is low, that paces temperature status updates.
// Assumes a synchronous active-low reset on the same clock.
`timescale 1ns/1ps
module status_refresh_timer #(
  parameter int PERIOD_CYCLES = 8000000,
  parameter int WIDTH         = 24
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      tick
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             tick;
  } timer_state_type;

  localparam logic [WIDTH-1:0] LAST = WIDTH'(PERIOD_CYCLES - 1);

  timer_state_type state_reg;
  timer_state_type state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.tick = 1'b0;
    if (!run) begin
      state_next.count = '0;
    end else if (state_reg.count >= LAST) begin
      // Tick no later than the period so status never goes stale
      state_next.count = '0;
      state_next.tick  = 1'b1;
    end else begin
      state_next.count = state_reg.count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;

endmodule : status_refresh_timer

// file: hw/sdram_mode_reg_three_mpr.sv
// Third mode register of the memory device: decode of the set command,
// the pattern scratch store path and the read redirection it controls.
// Assumes command pins sampled on ref_clk, one command per cycle.
//
// Summary of operation
// RULE_01 - With write CRC on, each write burst grows from 8 to 10 UI.
// RULE_02 - Controller holds row, column and write strobes low for a set.
// RULE_03 - Loaded when select bits 20:18 equal 011; select 111 never used.
// RULE_04 - Bits 21, 17 and 13 must be written zero.
// RULE_05 - Bits 12:11 pick serial, parallel or staggered readout; 11 reserved.
// RULE_06 - Bits 10:9 give write delay 4, 5 or 6 clocks; 11 reserved.
// RULE_07 - Controller picks write delay by data rate bands.
// RULE_08 - Bits 8:6 pick refresh granularity; 011, 100, 111 reserved.
// RULE_09 - Bit 5 keeps temperature status in page 2 location 0 bits 4:3.
// RULE_10 - Temperature status refreshed at least every 32 ms.
// RULE_11 - Bit 4 enables per-device addressability.
// RULE_12 - Bit 3 selects gear-down, 2:1 internal clock ratio.
// RULE_13 - Bit 2 enables scratch store access; zero restores normal use.
// RULE_14 - Bits 1:0 select page 0 to 3; page 3 not for controller use.
// RULE_15 - Controller precharges all banks before enabling store access.
// RULE_16 - In store access, reads go to a location chosen by address.
// RULE_17 - Mode register readout is split into lower and upper halves.
// RULE_18 - Only reads and writes allowed while store access is on; set commands are also accepted without an error.
// RULE_19 - Reset accepted during store access; full re-initialization.
// RULE_20 - Store serves register readout, patterns and error frame readout.
// RULE_21 - Second mode register bit 12 switches write CRC.
// RULE_22 - Controller never programs reserved field codes.
`timescale 1ns/1ps
module sdram_mode_reg_three_mpr
  import mode_reg_three_pkg::*;
#(
  parameter int TEMP_REFRESH_CYCLES_P = mode_reg_three_pkg::TEMP_REFRESH_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        cke,
  input  wire logic        cs_n,
  input  wire logic        act_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [1:0]  bg,
  input  wire logic [1:0]  ba,
  input  wire logic        a17,
  input  wire logic [13:0] addr,
  input  wire logic        dm_enable,
  input  wire logic [1:0]  temp_sensor,
  input  wire logic [31:0] error_frame,
  input  wire logic [7:0]  wr_pattern_byte,
  output logic [1:0]       read_format,
  output logic [2:0]       crc_mask_write_delay,
  output logic [2:0]       refresh_mode,
  output logic             temp_status_en,
  output logic             per_device_en,
  output logic             gear_down_en,
  output logic             pattern_access_en,
  output logic [1:0]       page_select,
  output logic             write_crc_en,
  output logic [3:0]       write_burst_ui,
  output logic             rd_redirect_valid,
  output logic [7:0]       rd_redirect_data,
  output logic             rd_redirect_upper,
  output logic [1:0]       temp_status,
  output logic             reserved_code_err,
  output logic             reserved_bit_err,
  output logic             bad_select_err,
  output logic             illegal_cmd_err
);

  import mode_reg_three_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    access_mode_type mode;
    logic [1:0]      read_format;
    logic [1:0]      delay_code;
    logic [2:0]      refresh_mode;
    logic            temp_en;
    logic            per_dev;
    logic            gear;
    logic [1:0]      page;
    logic            crc_en;
    logic [2:0]      delay_clk;
    logic [3:0]      burst_ui;
    logic            rd_valid;
    logic [7:0]      rd_data;
    logic            rd_upper;
    logic [1:0]      temp_status;
    logic            res_code_err;
    logic            res_bit_err;
    logic            bad_sel_err;
    logic            illegal_err;
    logic [3:0][7:0] patterns;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic                temp_tick;
  logic [MR_WIDTH-1:0] mr_bits;
  logic [2:0]          mr_select;
  logic [MR_WIDTH-1:0] mr3_image;
  logic                cmd_live;
  logic                cmd_set;
  logic                cmd_read;
  logic                cmd_write;
  logic                cmd_other;
  logic [1:0]          loc;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  assign mr_bits   = {bg, ba, a17, 3'h0, addr};
  assign mr_select = mr_bits[20:18];
  assign loc       = addr[1:0];
  assign cmd_live  = cke && !cs_n;
  // A set command needs all three strobes low
  assign cmd_set   = cmd_live && act_n && !ras_n && !cas_n && !we_n; // RULE_02
  assign cmd_read  = cmd_live && act_n && ras_n && !cas_n && we_n;
  assign cmd_write = cmd_live && act_n && ras_n && !cas_n && !we_n;
  // Deselect and no-op are idle, not commands
  assign cmd_other = (cmd_live && !act_n)
                  || (cmd_live && !(ras_n && cas_n && we_n)
                      && !cmd_read && !cmd_write && !cmd_set)
                  || !cke;

  // Present register contents, rebuilt for readout
  assign mr3_image = {1'b0, SEL_MR3, 1'b0, 3'h0, 1'b0,
                      state_reg.read_format, state_reg.delay_code,
                      state_reg.refresh_mode, state_reg.temp_en,
                      state_reg.per_dev, state_reg.gear,
                      (state_reg.mode == MODE_PATTERN), state_reg.page};

  // ****************************************************************
  // Temperature status pacing
  // ****************************************************************
  status_refresh_timer #(
    .PERIOD_CYCLES (TEMP_REFRESH_CYCLES_P),
    .WIDTH         (TIMER_WIDTH)
  ) u_temp_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .run     (state_reg.temp_en),
    .tick    (temp_tick)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next          = state_reg;
    state_next.rd_valid = 1'b0;

    // Write CRC comes from the second mode register
    if (cmd_set && mr_select == SEL_MR2) begin
      state_next.crc_en = mr_bits[POS_CRC_EN_MR2]; // RULE_21
    end

    if (cmd_set && mr_select == SEL_FORBIDDEN) begin
      // Forbidden select loads nothing
      state_next.bad_sel_err = 1'b1; // RULE_03
    end

    if (cmd_set && mr_select == SEL_MR3) begin // RULE_03
      if (mr_bits[POS_RSV_21] || mr_bits[POS_RSV_17]
          || mr_bits[POS_RSV_13]) begin
        state_next.res_bit_err = 1'b1; // RULE_04
      end
      state_next.read_format  = mr_bits[POS_FMT_LO +: 2]; // RULE_05
      state_next.delay_code   = mr_bits[POS_DLY_LO +: 2]; // RULE_06
      state_next.refresh_mode = mr_bits[POS_REF_LO +: 3]; // RULE_08
      state_next.temp_en      = mr_bits[POS_TEMP_EN]; // RULE_09
      state_next.per_dev      = mr_bits[POS_PER_DEV]; // RULE_11
      state_next.gear         = mr_bits[POS_GEAR]; // RULE_12
      state_next.page         = mr_bits[POS_PAGE_LO +: 2]; // RULE_14
      if (mr_bits[POS_FMT_LO +: 2] == FMT_RESERVED
          || mr_bits[POS_DLY_LO +: 2] == 2'h3
          || mr_bits[POS_REF_LO +: 3] == REF_RSV_A
          || mr_bits[POS_REF_LO +: 3] == REF_RSV_B
          || mr_bits[POS_REF_LO +: 3] == REF_RSV_C) begin
        state_next.res_code_err = 1'b1; // RULE_05
      end
      if (mr_bits[POS_ACCESS]) begin
        // A fresh entry starts with a clean command record
        if (state_reg.mode != MODE_PATTERN) begin
          state_next.illegal_err = 1'b0;
        end
        state_next.mode = MODE_PATTERN; // RULE_13
      end else begin
        state_next.mode = MODE_NORMAL; // RULE_13
      end
    end

    // Burst length and write delay follow the latest settings
    state_next.burst_ui = state_next.crc_en ? BURST_UI_CRC
                                            : BURST_UI_PLAIN; // RULE_01
    if (state_next.crc_en && dm_enable) begin
      unique case (state_next.delay_code) // RULE_06
        DLY_CODE_4CK: state_next.delay_clk = DLY_CLK_4;
        DLY_CODE_5CK: state_next.delay_clk = DLY_CLK_5;
        DLY_CODE_6CK: state_next.delay_clk = DLY_CLK_6;
        default:      state_next.delay_clk = DLY_CLK_RESET;
      endcase
    end else begin
      state_next.delay_clk = DLY_CLK_RESET;
    end

    // Sensor level is caught on each period tick while enabled
    if (state_reg.temp_en && temp_tick) begin
      state_next.temp_status = temp_sensor; // RULE_10
    end else if (!state_reg.temp_en && state_next.temp_en) begin
      state_next.temp_status = temp_sensor; // RULE_09
    end

    unique case (state_reg.mode)
      MODE_NORMAL: begin
      end
      MODE_PATTERN: begin
        if (cmd_other) begin
          // Set still wins over the clear of a new entry
          state_next.illegal_err = 1'b1; // RULE_18
        end
        if (cmd_read) begin // RULE_16
          state_next.rd_valid = 1'b1;
          state_next.rd_upper = 1'b0;
          unique case (state_reg.page) // RULE_20
            PAGE_PATTERN: begin
              state_next.rd_data = state_reg.patterns[loc];
            end
            PAGE_ERROR: begin
              state_next.rd_data = error_frame[8*loc +: 8];
            end
            PAGE_MODE_READ: begin
              unique case (loc)
                2'h0: state_next.rd_data = {3'h0, state_reg.temp_status,
                                            3'h0}; // RULE_09
                2'h1: state_next.rd_data = mr3_image[7:0]; // RULE_17
                2'h2: begin
                  state_next.rd_data  = {2'h0, mr3_image[13:8]}; // RULE_17
                  state_next.rd_upper = 1'b1;
                end
                2'h3: state_next.rd_data = {7'h0, state_reg.crc_en};
              endcase
            end
            // Page 3 is held back; it reads as zero
            2'h3: state_next.rd_data = 8'h00; // RULE_14
          endcase
        end
        if (cmd_write && state_reg.page == PAGE_PATTERN) begin
          state_next.patterns[loc] = wr_pattern_byte; // RULE_20
        end
      end
      default: begin
        state_next.mode = MODE_NORMAL;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Reset drops store access at the first ref_clk edge with rst_n low, whatever mode was active
  // Patterns clear too, so an early store read returns a known byte
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg              <= '0; // RULE_19
      state_reg.mode         <= MODE_NORMAL; // RULE_19
      state_reg.burst_ui     <= BURST_UI_PLAIN;
      state_reg.delay_clk    <= DLY_CLK_RESET;
      state_reg.patterns     <= {4{PATTERN_RESET}};
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign read_format          = state_reg.read_format;
  assign crc_mask_write_delay = state_reg.delay_clk;
  assign refresh_mode         = state_reg.refresh_mode;
  assign temp_status_en       = state_reg.temp_en;
  assign per_device_en        = state_reg.per_dev;
  assign gear_down_en         = state_reg.gear;
  // One-hot mode code: bit 1 is the store access state, so the pin
  // is a plain register bit rather than a decoded compare
  assign pattern_access_en    = state_reg.mode[1];
  assign page_select          = state_reg.page;
  assign write_crc_en         = state_reg.crc_en;
  assign write_burst_ui       = state_reg.burst_ui;
  assign rd_redirect_valid    = state_reg.rd_valid;
  assign rd_redirect_data     = state_reg.rd_data;
  assign rd_redirect_upper    = state_reg.rd_upper;
  assign temp_status          = state_reg.temp_status;
  assign reserved_code_err    = state_reg.res_code_err;
  assign reserved_bit_err     = state_reg.res_bit_err;
  assign bad_select_err       = state_reg.bad_sel_err;
  assign illegal_cmd_err      = state_reg.illegal_err;

endmodule : sdram_mode_reg_three_mpr

// file: dv/mode_reg_three_properties.sv
// Concurrent checks on the third mode register decoder ports.
// Assumes one ref_clk domain and a synchronous active-low rst_n.
`timescale 1ns/1ps
module mode_reg_three_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        act_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [1:0]  bg,
  input wire logic [1:0]  ba,
  input wire logic [13:0] addr,
  input wire logic        dm_enable,
  input wire logic [2:0]  crc_mask_write_delay,
  input wire logic [2:0]  refresh_mode,
  input wire logic        gear_down_en,
  input wire logic        pattern_access_en,
  input wire logic [1:0]  page_select,
  input wire logic        write_crc_en,
  input wire logic [3:0]  write_burst_ui,
  input wire logic        rd_redirect_valid,
  input wire logic        rd_redirect_upper,
  input wire logic        bad_select_err,
  input wire logic        illegal_cmd_err
);
  import mode_reg_three_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Command decode
  // ****************************************
  logic       mrs;
  logic       rd;
  logic       legal;
  logic [2:0] sel;
  logic [1:0] dly_q;
  assign mrs   = cke && !cs_n && act_n && !ras_n && !cas_n && !we_n;
  assign rd    = cke && !cs_n && act_n && ras_n && !cas_n && we_n;
  assign sel   = {bg[0], ba};
  // Deselect, nop, set, read and write stay legal; all else offends
  assign legal = cke && (cs_n || mrs ||
                         (act_n && ras_n && (!cas_n || we_n)));
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      dly_q <= 2'h0;
    else if (mrs && sel == SEL_MR3)
      dly_q <= addr[10:9];
  end
  // ****************************************
  // Properties
  // ****************************************
  property p_burst;
    write_burst_ui == (write_crc_en ? BURST_UI_CRC : BURST_UI_PLAIN);
  endproperty
  a_burst: assert property (p_burst)
    else $error("write burst length wrong");
  property p_set;
    mrs && sel == SEL_MR3 |=> refresh_mode == $past(addr[8:6]) &&
      gear_down_en == $past(addr[3]) &&
      pattern_access_en == $past(addr[2]) &&
      page_select == $past(addr[1:0]);
  endproperty
  a_set: assert property (p_set)
    else $error("fields not loaded by set");
  property p_badsel;
    mrs && sel == SEL_FORBIDDEN |=>
      bad_select_err && $stable(page_select) && $stable(refresh_mode);
  endproperty
  a_badsel: assert property (p_badsel)
    else $error("forbidden select mishandled");
  // Settled only once code and crc have held for one edge and mask for two edges
  property p_delay;
    $stable(dly_q) && $stable(write_crc_en) &&
      dm_enable == $past(dm_enable) && dm_enable == $past(dm_enable, 2)
      |-> crc_mask_write_delay ==
        ((write_crc_en && dm_enable && dly_q != 2'h3) ?
         3'h4 + {1'b0, dly_q} : 3'h0);
  endproperty
  a_delay: assert property (p_delay)
    else $error("write delay wrong");
  property p_redir;
    rd && pattern_access_en |=> rd_redirect_valid &&
      rd_redirect_upper == ($past(page_select) == PAGE_MODE_READ &&
                            $past(addr[1:0]) == 2'h2);
  endproperty
  a_redir: assert property (p_redir)
    else $error("store read not redirected");
  property p_noread;
    !(rd && pattern_access_en) |=> !rd_redirect_valid;
  endproperty
  a_noread: assert property (p_noread)
    else $error("redirect without store read");
  property p_illegal;
    pattern_access_en && !legal |=> illegal_cmd_err;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("illegal command not flagged");
  property p_reset;
    disable iff (1'b0)
    $rose(rst_n) |-> !pattern_access_en && !illegal_cmd_err &&
      !bad_select_err && write_burst_ui == BURST_UI_PLAIN;
  endproperty
  a_reset: assert property (p_reset)
    else $error("state not cleared by reset");
  c_redir: cover property (rd && pattern_access_en);
  c_illegal: cover property (pattern_access_en && !legal);
  c_badsel: cover property (mrs && sel == SEL_FORBIDDEN);
endmodule : mode_reg_three_checker

bind sdram_mode_reg_three_mpr mode_reg_three_checker i_checker (.*);

// file: dv/ctrl_model.sv
// Memory controller model driving the command and address pins.
// Assumes its tasks are entered at a falling edge of ref_clk.
`timescale 1ns/1ps
module ctrl_model (
  input  wire logic   ref_clk,
  output logic        cke,
  output logic        cs_n,
  output logic        act_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [1:0]  bg,
  output logic [1:0]  ba,
  output logic        a17,
  output logic [13:0] addr
);
  initial begin
    {cke, cs_n, act_n, ras_n, cas_n, we_n} = 6'h3F;
    {bg, ba, a17, addr} = 19'h00000;
  end
  // ****************************************
  // Command tasks
  // ****************************************
  // Driven across one rising edge and left driven until the next task; back-to-back calls chain cleanly
  task automatic cmd(input logic [3:0] c, input logic [21:0] v);
    {act_n, ras_n, cas_n, we_n} = c;
    cs_n = 1'b0;
    {bg, ba, a17} = v[21:17];
    addr = v[13:0];
    @(negedge ref_clk);
  endtask : cmd
  task automatic idle();
    cs_n = 1'b1;
    // Deselected address carries no meaning, so never leave it steady
    addr = ~addr;
    @(negedge ref_clk);
  endtask : idle
  task automatic mrs(input logic [21:0] v);
    cmd(4'h8, v);
  endtask : mrs
  task automatic enter_store(input logic [21:0] v);
    cmd(4'hA, 22'h000400);
    idle();
    mrs(v | 22'h000004);
  endtask : enter_store
endmodule : ctrl_model

// file: dv/testbench.sv
// Self-checking bench for the third mode register decoder.
// Assumes the controller model and the bound property checker.
`timescale 1ns/1ps
module testbench;
  import mode_reg_three_pkg::*;
  localparam int TEMP_CYC = 50;
  logic        ref_clk, rst_n, cke, cs_n, act_n, ras_n, cas_n, we_n, a17;
  logic        dm_enable, temp_status_en, per_device_en, gear_down_en;
  logic        pattern_access_en, write_crc_en, rd_redirect_valid;
  logic        rd_redirect_upper, reserved_code_err, reserved_bit_err;
  logic        bad_select_err, illegal_cmd_err;
  logic [1:0]  bg, ba, temp_sensor, read_format, page_select, temp_status;
  logic [2:0]  crc_mask_write_delay, refresh_mode;
  logic [3:0]  write_burst_ui;
  logic [7:0]  wr_pattern_byte, rd_redirect_data;
  logic [13:0] addr;
  logic [31:0] error_frame;
  logic [7:0]  pat [4];
  int          ref_codes [5] = '{0, 1, 2, 5, 6};
  int          mismatches, n_compared, mr3, i;
  bit          crc;
  sdram_mode_reg_three_mpr #(.TEMP_REFRESH_CYCLES_P(TEMP_CYC))
    i_sdram_mode_reg_three_mpr (.*);
  ctrl_model i_ctrl_model (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ****************************************
  // Checking tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  task automatic check_fields();
    chk("format", read_format, mr3[12:11]);
    chk("delay", crc_mask_write_delay, (crc && dm_enable &&
        mr3[10:9] != 3) ? 4 + mr3[10:9] : 0);
    chk("refresh", refresh_mode, mr3[8:6]);
    chk("flags", {temp_status_en, per_device_en}, mr3[5:4]);
    chk("gear", gear_down_en, mr3[3]);
    chk("access", {pattern_access_en, page_select}, mr3[2:0]);
    chk("burst", write_burst_ui, crc ? 10 : 8);
    chk("crc", write_crc_en, crc);
  endtask : check_fields
  task automatic set_mr3(input int v);
    i_ctrl_model.mrs(22'(v) | 22'h0C0000);
    i_ctrl_model.idle();
    mr3 = v;
    check_fields();
  endtask : set_mr3
  task automatic set_crc(input bit b);
    i_ctrl_model.mrs(22'h080000 | (22'(b) << 12));
    i_ctrl_model.idle();
    crc = b;
  endtask : set_crc
  task automatic store(input int v);
    i_ctrl_model.enter_store(22'(v) | 22'h0C0000);
    i_ctrl_model.idle();
    mr3 = v | 4;
    check_fields();
    chk("illegal", illegal_cmd_err, 0);
  endtask : store
  task automatic rd_chk(input int loc, input int exp);
    i_ctrl_model.cmd(4'hD, 22'(loc));
    chk("valid", rd_redirect_valid, 1);
    chk("data", rd_redirect_data, exp);
    chk("upper", rd_redirect_upper, mr3[1:0] == 2 && loc == 2);
  endtask : rd_chk
  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h5960e86e));
    {rst_n, mismatches, n_compared, crc, mr3} = '0;
    {dm_enable, temp_sensor, wr_pattern_byte} = 11'h600;
    error_frame = $urandom;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    i_ctrl_model.idle();
    check_fields();
    set_crc(1);
    for (i = 0; i < 10; i++) begin
      dm_enable = (i != 7);
      if (i == 5)
        set_crc(0);
      set_mr3((i % 3) << 11 | (i % 3) << 9 | ref_codes[i % 5] << 6 |
              ($urandom & 32'h38) | ($urandom % 3));
    end
    set_crc(1);
    set_mr3(32'h1E00);
    chk("code_err", reserved_code_err, 1);
    set_mr3(32'h222000);
    chk("bit_err", reserved_bit_err, 1);
    i_ctrl_model.mrs(22'h1C0007);
    i_ctrl_model.idle();
    check_fields();
    chk("sel_err", bad_select_err, 1);
    set_mr3(32'h20);
    chk("temp", temp_status, 2);
    temp_sensor = 2'h1;
    repeat (TEMP_CYC + 3) @(negedge ref_clk);
    chk("temp", temp_status, 1);
    store(32'h20);
    for (i = 0; i < 4; i++) begin
      pat[i] = 8'($urandom);
      wr_pattern_byte = pat[i];
      i_ctrl_model.cmd(4'hC, 22'(i));
    end
    for (i = 0; i < 4; i++)
      rd_chk(i, pat[i]);
    set_mr3(32'h25);
    for (i = 0; i < 4; i++)
      rd_chk(i, error_frame[8 * i +: 8]);
    set_mr3(32'h116E);
    rd_chk(0, temp_sensor << 3);
    rd_chk(1, 32'h6E);
    rd_chk(2, 32'h11);
    rd_chk(3, crc);
    set_mr3(32'h0);
    i_ctrl_model.cmd(4'hD, 22'h1);
    chk("valid", rd_redirect_valid, 0);
    store(32'h0);
    i_ctrl_model.cmd(4'h7, 22'h0);
    chk("illegal", illegal_cmd_err, 1);
    rst_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    {crc, mr3} = '0;
    i_ctrl_model.idle();
    check_fields();
    chk("errs", {reserved_code_err, reserved_bit_err, bad_select_err,
        illegal_cmd_err}, 0);
    finish_test();
  end
endmodule : testbench
